// ---- logic/smc_pkg.sv ----
// shared types and constants for the subtract/multiply/compare/bit datapath
package smc_pkg;

  localparam int DATA_W = 8;
  localparam int IDX_W = 3;

  // values after reset
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DEST_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // arithmetic constants
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] BIT_LSB = 8'h01;
  localparam logic [DATA_W:0] MUL_ONE = 9'h001;
  localparam logic [IDX_W:0] SHIFT_RIGHT_BASE = 4'h8;

  typedef enum logic [3:0] {
    OP_SUB_FROM_REG = 4'h0,
    OP_SUB_BORROW = 4'h1,
    OP_PRODUCT = 4'h2,
    OP_PRODUCT_ALT = 4'h3,
    OP_SHIFT_LEFT = 4'h4,
    OP_SHIFT_RIGHT = 4'h5,
    OP_SHIFT_RIGHT_ARITH = 4'h6,
    OP_COMPARE = 4'h7,
    OP_COMPARE_ALT = 4'h8,
    OP_BIT_TEST = 4'h9,
    OP_BIT_HIGH = 4'hA,
    OP_BIT_LOW = 4'hB,
    OP_BIT_TOGGLE = 4'hC
  } smc_op_t;

  typedef enum logic [1:0] {
    FORM_IMM = 2'h0,
    FORM_REG3 = 2'h1,
    FORM_REG2 = 2'h2,
    FORM_MEM = 2'h3
  } smc_form_t;

  typedef struct packed {
    smc_op_t op;
    smc_form_t form;
    logic [DATA_W-1:0] r1;
    logic [DATA_W-1:0] r2;
    logic [DATA_W-1:0] r3;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] mem_word;
    logic [IDX_W-1:0] idx;
  } smc_req_t;

  typedef struct packed {
    logic c;
    logic v;
    logic z;
  } smc_flags_t;

endpackage

// ---- logic/smc_mul.sv ----
// single-cycle multiplier, multiplicand optionally signed
`timescale 1ns/100ps
`default_nettype none

module smc_mul #(
  parameter int W = 8
) (
  // operands
  input wire logic [W-1:0] mcand,
  input wire logic [W:0] mplier,
  input wire logic mcand_signed,
  // result
  output logic [2*W-1:0] product
);

  logic signed [2*W+2:0] mcand_x;
  logic signed [2*W+2:0] mplier_x;
  logic signed [2*W+2:0] full;

  // both operands are widened to three bits past the product width on purpose;
  // the multiplier is never negative, so it is zero-extended
  assign mcand_x = {{(W+3){mcand_signed & mcand[W-1]}}, mcand};
  assign mplier_x = {{(W+2){1'b0}}, mplier};
  assign full = mcand_x * mplier_x;
  assign product = full[2*W-1:0];

endmodule

`default_nettype wire

// ---- logic/smc_alu.sv ----
// subtract, multiply, compare and single-bit datapath with result flops
`timescale 1ns/100ps
`default_nettype none

module smc_alu (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // operation request from the decoder
  input wire logic req_valid,
  input wire smc_pkg::smc_req_t req,
  // flag preload from the rest of the cpu
  input wire logic flag_wr,
  input wire smc_pkg::smc_flags_t flag_in,
  // results
  output logic [smc_pkg::DATA_W-1:0] acc,
  output smc_pkg::smc_flags_t flags,
  output logic dest_we,
  output logic [smc_pkg::DATA_W-1:0] dest_data,
  output logic done
);

  localparam int W = smc_pkg::DATA_W;

  logic [W-1:0] acc_q, acc_d, dest_q, dest_d;
  logic dest_we_q, we_d, done_q;
  smc_pkg::smc_flags_t flags_q, flags_d;
  logic legal, accept, upd_z, is_cmp;

  logic [W-1:0] other, sub_x, sub_y;
  logic borrow;
  logic [W:0] diff;
  logic [W-1:0] mul_a;
  logic [W:0] mul_b;
  logic mul_sgn;
  logic [smc_pkg::IDX_W:0] shamt;
  logic [2*W-1:0] prod;
  logic [W-1:0] mask;

  // second source by form; three-register forms use reg2 here
  always_comb begin
    unique case (req.form)
      smc_pkg::FORM_IMM: other = req.imm;
      smc_pkg::FORM_MEM: other = req.mem_word;
      smc_pkg::FORM_REG3, smc_pkg::FORM_REG2: other = req.r2;
    endcase
  end

  // operand steering for the shared subtractor and multiplier
  always_comb begin
    sub_x = req.r1;
    sub_y = other;
    borrow = 1'b0;
    mul_a = other;
    mul_b = {1'b0, req.r1};
    mul_sgn = 1'b0;
    shamt = {1'b0, req.idx};
    if (req.form == smc_pkg::FORM_REG3) begin
      sub_x = req.r3;
      mul_b = {1'b0, req.r3};
    end
    unique case (req.op)
      smc_pkg::OP_SUB_BORROW: begin
        borrow = ~flags_q.c;
      end
      smc_pkg::OP_COMPARE, smc_pkg::OP_COMPARE_ALT: begin
        sub_x = other;
        sub_y = req.r1;
      end
      smc_pkg::OP_SHIFT_LEFT: begin
        mul_a = req.r1;
        mul_b = smc_pkg::MUL_ONE << shamt;
      end
      smc_pkg::OP_SHIFT_RIGHT, smc_pkg::OP_SHIFT_RIGHT_ARITH: begin
        // a multiply by 2^(8-n), so n=1 gives a one-place right shift in the high byte
        shamt = smc_pkg::SHIFT_RIGHT_BASE - {1'b0, req.idx};
        mul_a = req.r1;
        mul_b = smc_pkg::MUL_ONE << shamt;
        mul_sgn = (req.op == smc_pkg::OP_SHIFT_RIGHT_ARITH);
      end
      default: begin
      end
    endcase
  end

  // carry out of bit 8 is the borrow; carry flag is its inverse
  assign diff = {1'b0, sub_x} - {1'b0, sub_y} - {{W{1'b0}}, borrow};
  assign mask = smc_pkg::BIT_LSB << req.idx;

  smc_mul #(
    .W(W)
  ) u_mul (
    .mcand(mul_a),
    .mplier(mul_b),
    .mcand_signed(mul_sgn),
    .product(prod)
  );

  // result and flag selection
  always_comb begin
    acc_d = acc_q;
    dest_d = dest_q;
    we_d = 1'b0;
    flags_d = flags_q;
    legal = 1'b1;
    upd_z = 1'b0;
    is_cmp = 1'b0;
    unique case (req.op)
      smc_pkg::OP_SUB_FROM_REG, smc_pkg::OP_SUB_BORROW: begin
        // plain three-register subtract has no defined behaviour: refused
        legal = !(req.op == smc_pkg::OP_SUB_FROM_REG &&
                  req.form == smc_pkg::FORM_REG3);
        acc_d = diff[W-1:0];
        dest_d = diff[W-1:0];
        we_d = 1'b1;
        flags_d.c = ~diff[W];
        upd_z = 1'b1;
      end
      smc_pkg::OP_COMPARE, smc_pkg::OP_COMPARE_ALT: begin
        legal = (req.form != smc_pkg::FORM_REG3);
        acc_d = diff[W-1:0];
        flags_d.c = ~diff[W];
        upd_z = 1'b1;
        is_cmp = 1'b1;
      end
      smc_pkg::OP_PRODUCT, smc_pkg::OP_PRODUCT_ALT,
      smc_pkg::OP_SHIFT_LEFT, smc_pkg::OP_SHIFT_RIGHT,
      smc_pkg::OP_SHIFT_RIGHT_ARITH: begin
        // flags are left alone: software must not rely on them here
        acc_d = prod[W-1:0];
        dest_d = prod[2*W-1:W];
        we_d = 1'b1;
      end
      smc_pkg::OP_BIT_TEST: begin
        acc_d = req.r1 & mask;
        upd_z = 1'b1;
      end
      smc_pkg::OP_BIT_HIGH: begin
        acc_d = req.r1 | mask;
        dest_d = req.r1 | mask;
        we_d = 1'b1;
        upd_z = 1'b1;
      end
      smc_pkg::OP_BIT_LOW: begin
        acc_d = req.r1 & ~mask;
        dest_d = req.r1 & ~mask;
        we_d = 1'b1;
        upd_z = 1'b1;
      end
      smc_pkg::OP_BIT_TOGGLE: begin
        acc_d = req.r1 ^ mask;
        dest_d = req.r1 ^ mask;
        we_d = 1'b1;
        upd_z = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    if (upd_z) begin
      flags_d.z = (acc_d == smc_pkg::ZERO_BYTE);
    end
    if (is_cmp) begin
      flags_d.v = flags_d.c & ~flags_d.z;
    end
  end

  assign accept = req_valid & legal;

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= smc_pkg::ACC_RESET;
    end else if (accept) begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dest_q <= smc_pkg::DEST_RESET;
      dest_we_q <= 1'b0;
    end else begin
      dest_we_q <= accept & we_d;
      if (accept) begin
        dest_q <= dest_d;
      end
    end
  end

  // an accepted operation wins over a preload in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= '{c: smc_pkg::FLAG_RESET, v: smc_pkg::FLAG_RESET,
                   z: smc_pkg::FLAG_RESET};
    end else if (accept) begin
      flags_q <= flags_d;
    end else if (flag_wr) begin
      flags_q <= flag_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= accept;
    end
  end

  assign acc = acc_q;
  assign flags = flags_q;
  assign dest_we = dest_we_q;
  assign dest_data = dest_q;
  assign done = done_q;

  // checking helpers: request and flags as they stood at issue
  smc_pkg::smc_req_t p_q;
  smc_pkg::smc_flags_t pf_q;
  logic [W:0] pb_q;

  always_ff @(posedge clock) begin
    p_q <= req;
    pf_q <= flags_q;
    pb_q <= {{W{1'b0}}, ~flags_q.c};
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // op comes in as an argument so that the sampled value is used
  function automatic logic is_cmp_p(smc_pkg::smc_op_t op);
    return op == smc_pkg::OP_COMPARE || op == smc_pkg::OP_COMPARE_ALT;
  endfunction

  a_sub_two_reg: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_FROM_REG &&
    p_q.form == smc_pkg::FORM_REG2 |-> acc_q == W'(p_q.r1 - p_q.r2) &&
    dest_we_q && dest_q == acc_q && flags_q.c == (p_q.r1 >= p_q.r2))
    else $error("two-register subtract wrong");
  a_sub_mem_word: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_FROM_REG &&
    p_q.form == smc_pkg::FORM_MEM |-> acc_q == W'(p_q.r1 - p_q.mem_word) &&
    dest_q == acc_q && flags_q.c == (p_q.r1 >= p_q.mem_word))
    else $error("memory subtract wrong");
  a_sub_imm_form: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_FROM_REG &&
    p_q.form == smc_pkg::FORM_IMM |-> acc_q == W'(p_q.r1 - p_q.imm) &&
    dest_q == acc_q && flags_q.c == (p_q.r1 >= p_q.imm))
    else $error("immediate subtract wrong");
  a_sbb_imm_form: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_BORROW &&
    p_q.form == smc_pkg::FORM_IMM |->
    acc_q == W'({1'b0, p_q.r1} - {1'b0, p_q.imm} - pb_q) &&
    flags_q.c == ({1'b0, p_q.r1} >= {1'b0, p_q.imm} + pb_q))
    else $error("immediate borrow subtract wrong");
  a_sbb_three_reg: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_BORROW &&
    p_q.form == smc_pkg::FORM_REG3 |->
    acc_q == W'({1'b0, p_q.r3} - {1'b0, p_q.r2} - pb_q) &&
    dest_q == acc_q &&
    flags_q.c == ({1'b0, p_q.r3} >= {1'b0, p_q.r2} + pb_q))
    else $error("three-register borrow subtract wrong");
  a_sbb_two_reg: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_BORROW &&
    p_q.form == smc_pkg::FORM_REG2 |->
    acc_q == W'({1'b0, p_q.r1} - {1'b0, p_q.r2} - pb_q) &&
    flags_q.c == ({1'b0, p_q.r1} >= {1'b0, p_q.r2} + pb_q))
    else $error("two-register borrow subtract wrong");
  a_sbb_mem_word: assert property (
    done_q && p_q.op == smc_pkg::OP_SUB_BORROW &&
    p_q.form == smc_pkg::FORM_MEM |->
    acc_q == W'({1'b0, p_q.r1} - {1'b0, p_q.mem_word} - pb_q) &&
    flags_q.c == ({1'b0, p_q.r1} >= {1'b0, p_q.mem_word} + pb_q))
    else $error("memory borrow subtract wrong");
  a_mul_imm_form: assert property (
    done_q && (p_q.op == smc_pkg::OP_PRODUCT ||
    p_q.op == smc_pkg::OP_PRODUCT_ALT) && p_q.form == smc_pkg::FORM_IMM |->
    {dest_q, acc_q} == (16'(p_q.imm) * 16'(p_q.r1)) && dest_we_q)
    else $error("immediate product wrong");
  a_mul_three_reg: assert property (
    done_q && (p_q.op == smc_pkg::OP_PRODUCT ||
    p_q.op == smc_pkg::OP_PRODUCT_ALT) && p_q.form == smc_pkg::FORM_REG3 |->
    {dest_q, acc_q} == (16'(p_q.r2) * 16'(p_q.r3)))
    else $error("three-register product wrong");
  a_mul_two_reg: assert property (
    done_q && (p_q.op == smc_pkg::OP_PRODUCT ||
    p_q.op == smc_pkg::OP_PRODUCT_ALT) && p_q.form == smc_pkg::FORM_REG2 |->
    {dest_q, acc_q} == (16'(p_q.r2) * 16'(p_q.r1)))
    else $error("two-register product wrong");
  a_mul_mem_word: assert property (
    done_q && (p_q.op == smc_pkg::OP_PRODUCT ||
    p_q.op == smc_pkg::OP_PRODUCT_ALT) && p_q.form == smc_pkg::FORM_MEM |->
    {dest_q, acc_q} == (16'(p_q.mem_word) * 16'(p_q.r1)))
    else $error("memory product wrong");
  a_shift_left_val: assert property (
    done_q && p_q.op == smc_pkg::OP_SHIFT_LEFT |->
    {dest_q, acc_q} == (16'(p_q.r1) << p_q.idx))
    else $error("shift left wrong");
  a_shift_right_val: assert property (
    done_q && p_q.op == smc_pkg::OP_SHIFT_RIGHT |->
    {dest_q, acc_q} == (16'(p_q.r1) << (4'h8 - {1'b0, p_q.idx})))
    else $error("shift right wrong");
  a_shift_right_one: assert property (
    done_q && p_q.op == smc_pkg::OP_SHIFT_RIGHT && p_q.idx == 3'h1 |->
    dest_q == {1'b0, p_q.r1[7:1]} && acc_q == {p_q.r1[0], 7'h00})
    else $error("shift right by one wrong");
  a_shift_arith_val: assert property (
    done_q && p_q.op == smc_pkg::OP_SHIFT_RIGHT_ARITH |->
    {dest_q, acc_q} ==
    (16'($signed(p_q.r1)) << (4'h8 - {1'b0, p_q.idx})))
    else $error("arithmetic shift right wrong");
  a_cmp_imm_form: assert property (
    done_q && is_cmp_p(p_q.op) && p_q.form == smc_pkg::FORM_IMM |->
    acc_q == W'(p_q.imm - p_q.r1) && flags_q.c == (p_q.imm >= p_q.r1) &&
    !dest_we_q)
    else $error("immediate compare wrong");
  a_cmp_two_reg: assert property (
    done_q && is_cmp_p(p_q.op) && p_q.form == smc_pkg::FORM_REG2 |->
    acc_q == W'(p_q.r2 - p_q.r1) && flags_q.c == (p_q.r2 >= p_q.r1))
    else $error("two-register compare wrong");
  a_cmp_mem_word: assert property (
    done_q && is_cmp_p(p_q.op) && p_q.form == smc_pkg::FORM_MEM |->
    acc_q == W'(p_q.mem_word - p_q.r1) &&
    flags_q.c == (p_q.mem_word >= p_q.r1))
    else $error("memory compare wrong");
  a_cmp_greater: assert property (
    done_q && is_cmp_p(p_q.op) |-> flags_q.v == (flags_q.c && !flags_q.z))
    else $error("compare overflow flag wrong");
  a_bit_test_val: assert property (
    done_q && p_q.op == smc_pkg::OP_BIT_TEST |->
    acc_q == (p_q.r1 & (8'h01 << p_q.idx)) && !dest_we_q &&
    flags_q.c == pf_q.c && flags_q.v == pf_q.v)
    else $error("bit test wrong");
  a_bit_high_val: assert property (
    done_q && p_q.op == smc_pkg::OP_BIT_HIGH |->
    dest_q == (p_q.r1 | (8'h01 << p_q.idx)) && acc_q == dest_q &&
    flags_q.c == pf_q.c && flags_q.v == pf_q.v)
    else $error("bit force high wrong");
  a_bit_low_val: assert property (
    done_q && p_q.op == smc_pkg::OP_BIT_LOW |->
    dest_q == (p_q.r1 & ~(8'h01 << p_q.idx)) && acc_q == dest_q &&
    flags_q.c == pf_q.c && flags_q.v == pf_q.v)
    else $error("bit force low wrong");
  a_bit_toggle_val: assert property (
    done_q && p_q.op == smc_pkg::OP_BIT_TOGGLE |->
    dest_q == (p_q.r1 ^ (8'h01 << p_q.idx)) && acc_q == dest_q &&
    flags_q.c == pf_q.c && flags_q.v == pf_q.v)
    else $error("bit toggle wrong");
  a_zero_flag_val: assert property (
    done_q && !(p_q.op inside {smc_pkg::OP_PRODUCT, smc_pkg::OP_PRODUCT_ALT,
    smc_pkg::OP_SHIFT_LEFT, smc_pkg::OP_SHIFT_RIGHT,
    smc_pkg::OP_SHIFT_RIGHT_ARITH}) |-> flags_q.z == (acc_q == 8'h00))
    else $error("zero flag wrong");

  c_sub_borrow_in: cover property (done_q &&
    p_q.op == smc_pkg::OP_SUB_BORROW && !pf_q.c);
  c_cmp_greater: cover property (done_q && is_cmp_p(p_q.op) && flags_q.v);
  c_mul_back_to_back: cover property (done_q &&
    p_q.op == smc_pkg::OP_PRODUCT ##1 done_q);
  c_shift_arith_neg: cover property (done_q &&
    p_q.op == smc_pkg::OP_SHIFT_RIGHT_ARITH && p_q.r1[7]);

endmodule

`default_nettype wire

// ---- verif/smc_cpu_model.sv ----
// register file and data memory that feed operands to the datapath
`timescale 1ns/100ps
`default_nettype none

module smc_cpu_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // preload port used by the bench
  input wire logic ld_en,
  input wire logic [2:0] ld_sel,
  input wire logic [7:0] ld_val,
  // operand and destination selects
  input wire logic [2:0] sel1,
  input wire logic [2:0] sel2,
  input wire logic [2:0] sel3,
  input wire logic [7:0] maddr,
  input wire logic [2:0] dst,
  // writeback from the datapath
  input wire logic dest_we,
  input wire logic [7:0] dest_data,
  // operands
  output logic [7:0] r1,
  output logic [7:0] r2,
  output logic [7:0] r3,
  output logic [7:0] mem_word
);
  logic [7:0] regs_q [8];

  // writeback wins over a preload so a lost result would show in reg1
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (dest_we) begin
      regs_q[dst] <= dest_data;
    end else if (ld_en) begin
      regs_q[ld_sel] <= ld_val;
    end
  end

  assign r1 = regs_q[sel1];
  assign r2 = regs_q[sel2];
  assign r3 = regs_q[sel3];
  // fixed pattern: every address reads distinct data without a store
  assign mem_word = maddr ^ 8'hA5;
endmodule

`default_nettype wire

// ---- verif/smc_alu_tb_top.sv ----
// self-checking bench for the subtract/multiply/compare/bit datapath
`timescale 1ns/100ps
`default_nettype none

module smc_alu_tb_top;
  logic clock, rst, req_valid, flag_wr, ld_en, dest_we, done;
  logic [3:0] opc;
  logic [1:0] frm;
  logic [2:0] idx, ld_sel;
  logic [7:0] imm, maddr, ld_val, acc, dest_data, r1, r2, r3, mem_word;
  logic [7:0] va, vb, vc;
  smc_pkg::smc_flags_t flag_in, flags, vf;
  smc_pkg::smc_req_t req;
  int fails, cmp_count;

  assign req = {opc, frm, r1, r2, r3, imm, mem_word, idx};

  smc_alu dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .flag_wr(flag_wr), .flag_in(flag_in), .acc(acc), .flags(flags),
    .dest_we(dest_we), .dest_data(dest_data), .done(done));

  smc_cpu_model partner (.clock(clock), .rst(rst), .ld_en(ld_en),
    .ld_sel(ld_sel), .ld_val(ld_val), .sel1(3'h1), .sel2(3'h2),
    .sel3(3'h3), .maddr(maddr), .dst(3'h1), .dest_we(dest_we),
    .dest_data(dest_data), .r1(r1), .r2(r2), .r3(r3), .mem_word(mem_word));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmpf(string nm, smc_pkg::smc_flags_t e,
      smc_pkg::smc_flags_t g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // loads reg1..reg3 through the partner, then presets the flags
  task automatic setup(input logic [7:0] a, b, c, i, m,
      input logic [2:0] x, input logic [2:0] fl);
    va = a;
    vb = b;
    vc = c;
    vf = fl;
    imm = i;
    maddr = m;
    idx = x;
    for (int k = 0; k < 3; k++) begin
      ld_sel = 3'(k + 1);
      ld_val = (k == 0) ? a : (k == 1) ? b : c;
      ld_en = 1'b1;
      @(posedge clock);
      #1;
    end
    ld_en = 1'b0;
    flag_in = fl;
    flag_wr = 1'b1;
    @(posedge clock);
    #1 flag_wr = 1'b0;
  endtask

  // issues one operation and judges done, dest_we, acc and flags, and dest_data and reg1 when it writes
  task automatic run(input logic [3:0] o, input logic [1:0] f);
    logic [7:0] x, y, m, msk;
    logic [8:0] d;
    logic [15:0] p;
    logic [3:0] s;
    logic we, zu;
    smc_pkg::smc_flags_t ef;
    m = maddr ^ 8'hA5;
    msk = 8'h01 << idx;
    ef = vf;
    we = 1'b1;
    zu = 1'b1;
    case (o)
      smc_pkg::OP_SUB_FROM_REG, smc_pkg::OP_SUB_BORROW: begin
        x = (f == smc_pkg::FORM_REG3) ? vc : va;
        y = (f == smc_pkg::FORM_IMM) ? imm : (f == smc_pkg::FORM_MEM) ? m : vb;
        d = {1'b0, x} - {1'b0, y};
        d = d - {8'h00, o == smc_pkg::OP_SUB_BORROW && !vf.c};
        p = {d[7:0], d[7:0]};
        ef.c = ~d[8];
      end
      smc_pkg::OP_COMPARE, smc_pkg::OP_COMPARE_ALT: begin
        x = (f == smc_pkg::FORM_IMM) ? imm : (f == smc_pkg::FORM_MEM) ? m : vb;
        d = {1'b0, x} - {1'b0, va};
        p = {8'h00, d[7:0]};
        ef.c = ~d[8];
        ef.v = ~d[8] && d[7:0] != 8'h00;
        we = 1'b0;
      end
      smc_pkg::OP_PRODUCT, smc_pkg::OP_PRODUCT_ALT: begin
        x = (f == smc_pkg::FORM_IMM) ? imm : (f == smc_pkg::FORM_MEM) ? m :
          (f == smc_pkg::FORM_REG3) ? vc : va;
        y = (f == smc_pkg::FORM_REG3 || f == smc_pkg::FORM_REG2) ? vb : va;
        p = {8'h00, x} * {8'h00, y};
        zu = 1'b0;
      end
      smc_pkg::OP_SHIFT_LEFT, smc_pkg::OP_SHIFT_RIGHT,
      smc_pkg::OP_SHIFT_RIGHT_ARITH: begin
        s = (o == smc_pkg::OP_SHIFT_LEFT) ? {1'b0, idx} : 4'h8 - {1'b0, idx};
        x = (o == smc_pkg::OP_SHIFT_RIGHT_ARITH && va[7]) ? 8'hFF : 8'h00;
        p = {x, va} << s;
        zu = 1'b0;
      end
      smc_pkg::OP_BIT_TEST: begin
        p = {8'h00, va & msk};
        we = 1'b0;
      end
      smc_pkg::OP_BIT_HIGH: p = {2{va | msk}};
      smc_pkg::OP_BIT_LOW: p = {2{va & ~msk}};
      default: p = {2{va ^ msk}};
    endcase
    if (zu) ef.z = (p[7:0] == 8'h00);
    opc = o;
    frm = f;
    req_valid = 1'b1;
    @(posedge clock);
    #1 req_valid = 1'b0;
    cmp1("done", 1'b1, done);
    cmp1("dest_we", we, dest_we);
    cmp8("acc", p[7:0], acc);
    cmpf("flags", ef, flags);
    if (we) begin
      cmp8("dest_data", p[15:8], dest_data);
      @(posedge clock);
      #1 cmp8("reg1", p[15:8], r1);
    end
  endtask

  task automatic t_reset();
    cmp8("acc", 8'h00, acc);
    cmp8("dest_data", 8'h00, dest_data);
    cmpf("flags", 3'b000, flags);
    cmp1("done", 1'b0, done);
    cmp1("dest_we", 1'b0, dest_we);
    $display("test reset done");
  endtask

  task automatic t_sub();
    setup(8'h05, 8'h07, 8'h00, 8'h00, 8'h00, 3'h0, 3'b010);
    run(smc_pkg::OP_SUB_FROM_REG, smc_pkg::FORM_REG2);
    setup(8'h10, 8'h00, 8'h00, 8'h00, 8'hB5, 3'h0, 3'b000);
    run(smc_pkg::OP_SUB_FROM_REG, smc_pkg::FORM_MEM);
    setup(8'h80, 8'h00, 8'h00, 8'h81, 8'h00, 3'h0, 3'b111);
    run(smc_pkg::OP_SUB_FROM_REG, smc_pkg::FORM_IMM);
    setup(8'h10, 8'h00, 8'h00, 8'h0F, 8'h00, 3'h0, 3'b000);
    run(smc_pkg::OP_SUB_BORROW, smc_pkg::FORM_IMM);
    setup(8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'b001);
    run(smc_pkg::OP_SUB_BORROW, smc_pkg::FORM_REG3);
    setup(8'h40, 8'h3F, 8'h00, 8'h00, 8'h00, 3'h0, 3'b100);
    run(smc_pkg::OP_SUB_BORROW, smc_pkg::FORM_REG2);
    setup(8'h5A, 8'h00, 8'h00, 8'h00, 8'hFF, 3'h0, 3'b110);
    run(smc_pkg::OP_SUB_BORROW, smc_pkg::FORM_MEM);
    $display("test subtract done");
  endtask

  task automatic t_product();
    for (int f = 0; f < 4; f++) begin
      setup(8'hFF, 8'hFE, 8'h21, 8'h10, 8'h5A, 3'h0, 3'b101);
      run(smc_pkg::OP_PRODUCT, 2'(f));
      setup(8'h83, 8'hC9, 8'h7E, 8'hF1, 8'h1B, 3'h0, 3'b010);
      run(smc_pkg::OP_PRODUCT_ALT, 2'(f));
    end
    $display("test product done");
  endtask

  task automatic t_shift();
    for (int i = 0; i < 8; i++) begin
      for (int o = 4; o < 7; o++) begin
        setup(i[0] ? 8'h4D : 8'hB3, 8'h00, 8'h00, 8'h00, 8'h00, 3'(i), 3'b111);
        run(4'(o), smc_pkg::FORM_IMM);
      end
    end
    $display("test shift done");
  endtask

  task automatic t_compare();
    logic [7:0] v;
    for (int o = 7; o < 9; o++) begin
      for (int f = 0; f < 4; f++) begin
        for (int k = 0; k < 3; k++) begin
          v = 8'h3F + 8'(k);
          setup(8'h40, v, 8'h00, v, v ^ 8'hA5, 3'h0, 3'b010);
          if (f != 1) run(4'(o), 2'(f));
        end
      end
    end
    $display("test compare done");
  endtask

  task automatic t_bits();
    for (int o = 9; o < 13; o++) begin
      for (int i = 0; i < 8; i++) begin
        setup(8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 3'(i), 3'b101);
        run(4'(o), smc_pkg::FORM_IMM);
      end
    end
    setup(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'b010);
    run(smc_pkg::OP_BIT_LOW, smc_pkg::FORM_IMM);
    $display("test bits done");
  endtask

  // back-to-back requests; a preload in a request's cycle is lost
  task automatic t_order();
    setup(8'h21, 8'h03, 8'h00, 8'h10, 8'h00, 3'h0, 3'b010);
    @(posedge clock);
    #1 opc = smc_pkg::OP_PRODUCT;
    frm = smc_pkg::FORM_IMM;
    flag_in = 3'b101;
    flag_wr = 1'b1;
    req_valid = 1'b1;
    @(posedge clock);
    #1 flag_wr = 1'b0;
    opc = smc_pkg::OP_COMPARE;
    frm = smc_pkg::FORM_REG2;
    cmp1("done", 1'b1, done);
    cmp1("dest_we", 1'b1, dest_we);
    cmp8("acc", 8'h10, acc);
    cmp8("dest_data", 8'h02, dest_data);
    cmpf("flags", 3'b010, flags);
    @(posedge clock);
    #1 req_valid = 1'b0;
    cmp1("done", 1'b1, done);
    cmp1("dest_we", 1'b0, dest_we);
    cmp8("acc", 8'hE2, acc);
    cmpf("flags", 3'b000, flags);
    cmp8("reg1", 8'h02, r1);
    $display("test order done");
  endtask

  // refused requests must leave the compare result of t_order untouched
  task automatic t_refused();
    @(posedge clock);
    #1 req_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      opc = (k == 0) ? 4'hD : (k == 1) ? smc_pkg::OP_SUB_FROM_REG :
        (k == 2) ? smc_pkg::OP_COMPARE : smc_pkg::OP_COMPARE_ALT;
      frm = (k == 0) ? smc_pkg::FORM_IMM : smc_pkg::FORM_REG3;
      @(posedge clock);
      #1;
      cmp1("done", 1'b0, done);
      cmp1("dest_we", 1'b0, dest_we);
      cmp8("acc", 8'hE2, acc);
      cmp8("dest_data", 8'h02, dest_data);
      cmpf("flags", 3'b000, flags);
    end
    req_valid = 1'b0;
    $display("test refused done");
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    flag_wr = 1'b0;
    flag_in = 3'b000;
    ld_en = 1'b0;
    ld_sel = 3'h0;
    ld_val = 8'h00;
    opc = 4'h0;
    frm = 2'h0;
    idx = 3'h0;
    imm = 8'h00;
    maddr = 8'h00;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_sub();
    t_product();
    t_shift();
    t_compare();
    t_bits();
    t_order();
    t_refused();
    test_done();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule

`default_nettype wire
